// file: src/wire_master_consts.svh
// Constants for the single-wire bus master: timing, commands, widths.
// Assumes a 200 MHz ref_clk; every cycle count is derived from it here.
`ifndef WIRE_MASTER_CONSTS_SVH
`define WIRE_MASTER_CONSTS_SVH

// ==========================================================================
// Clock rate
`define CLK_MHZ 200

// ==========================================================================
// Times in microseconds (milliseconds where noted)
`define RESET_LOW_US 480
`define RESET_RX_US 480
`define PRESENCE_SAMPLE_US 70
`define SLOT_US 60
`define RECOVERY_US 1
`define WRITE1_LOW_US 6
`define READ_INIT_US 1
`define READ_SAMPLE_US 13
`define CONVERSION_DURATION_MS 750
`define COPY_PULLUP_MS 10

// ==========================================================================
// Cycle counts derived from the times
`define RESET_LOW_CYC (`RESET_LOW_US * `CLK_MHZ)
`define RESET_RX_CYC (`RESET_RX_US * `CLK_MHZ)
`define PRESENCE_SAMPLE_CYC (`PRESENCE_SAMPLE_US * `CLK_MHZ)
`define SLOT_CYC (`SLOT_US * `CLK_MHZ)
`define RECOVERY_CYC (`RECOVERY_US * `CLK_MHZ)
`define WRITE1_LOW_CYC (`WRITE1_LOW_US * `CLK_MHZ)
`define READ_INIT_CYC (`READ_INIT_US * `CLK_MHZ)
`define READ_SAMPLE_CYC (`READ_SAMPLE_US * `CLK_MHZ)
`define CONVERSION_DURATION_CYC (`CONVERSION_DURATION_MS * 1000 * `CLK_MHZ)
`define COPY_PULLUP_CYC (`COPY_PULLUP_MS * 1000 * `CLK_MHZ)

// ==========================================================================
// Function command codes and widths
`define CMD_START_CONVERSION 8'h44
`define CMD_COPY_WORKING 8'h48
`define CMD_READ_WORKING 8'hBE
`define CMD_QUERY_SUPPLY 8'hB4
`define CMD_RELOAD_NONVOLATILE 8'hB8
`define CMD_SELECT_BY_ID 8'h55
`define CRC_POLY_REFLECTED 8'h8C
`define CRC_INIT 8'h00
`define SLOT_CNT_W 18
`define PULLUP_CNT_W 32

`endif

// file: src/wire_master_pkg.sv
// Types shared by the bus master and its slot timing engine.
// Assumes nothing beyond the constants header.
package wire_master_pkg;

    // ======================================================================
    // User operations
    typedef enum logic [2:0] {
        OP_RESET = 3'h0,
        OP_WRITE_BYTE = 3'h1,
        OP_READ_BYTE = 3'h2,
        OP_WRITE_BIT = 3'h3,
        OP_READ_BIT = 3'h4,
        OP_PULLUP = 3'h5
    } op_t;

    // ======================================================================
    // Slot kinds handed to the timing engine
    typedef enum logic [1:0] {
        SLOT_RESET = 2'h0,
        SLOT_WRITE0 = 2'h1,
        SLOT_WRITE1 = 2'h2,
        SLOT_READ = 2'h3
    } slot_kind_t;

    // ======================================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SLOT = 2'h1,
        ST_PULLUP = 2'h2
    } seq_state_t;

    // ======================================================================
    // Engine states
    typedef enum logic [1:0] {
        EN_IDLE = 2'h0,
        EN_ACTIVE = 2'h1,
        EN_RECOVER = 2'h2
    } eng_state_t;

endpackage

// file: src/slot_if.sv
// Carrier between the byte sequencer and the slot timing engine.
// Assumes both ends run on ref_clk.
interface slot_if;
    logic start;
    wire_master_pkg::slot_kind_t kind;
    logic done;
    logic rx_bit;

    modport ctrl (output start, output kind, input done, input rx_bit);
    modport eng (input start, input kind, output done, output rx_bit);
endinterface

// file: src/slot_engine.sv
// Slot timing engine: drives one reset, write or read slot on the line.
// Assumes an open-drain line with an external pullup and a raw pin input.
`include "wire_master_consts.svh"

module slot_engine #(
    parameter int RESET_LOW = `RESET_LOW_CYC,
    parameter int RESET_RX = `RESET_RX_CYC,
    parameter int PRES_SAMPLE = `PRESENCE_SAMPLE_CYC,
    parameter int SLOT_LEN = `SLOT_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Sequencer side
    slot_if.eng s,
    // Line
    input wire logic dq_in,
    output logic dq_oe
);

    // ======================================================================
    // Derived points in a slot, counted from its falling edge; recovery end counted from the slot's end
    localparam logic [`SLOT_CNT_W-1:0] RST_LOW = `SLOT_CNT_W'(RESET_LOW);
    localparam logic [`SLOT_CNT_W-1:0] RST_SAMPLE = `SLOT_CNT_W'(RESET_LOW + PRES_SAMPLE);
    localparam logic [`SLOT_CNT_W-1:0] RST_END = `SLOT_CNT_W'(RESET_LOW + RESET_RX);
    localparam logic [`SLOT_CNT_W-1:0] SLOT_END = `SLOT_CNT_W'(SLOT_LEN);
    localparam logic [`SLOT_CNT_W-1:0] W1_LOW = `SLOT_CNT_W'(`WRITE1_LOW_CYC);
    localparam logic [`SLOT_CNT_W-1:0] RD_LOW = `SLOT_CNT_W'(`READ_INIT_CYC);
    localparam logic [`SLOT_CNT_W-1:0] RD_SAMPLE = `SLOT_CNT_W'(`READ_SAMPLE_CYC);
    localparam logic [`SLOT_CNT_W-1:0] REC_END = `SLOT_CNT_W'(`RECOVERY_CYC);

    wire_master_pkg::eng_state_t state_reg;
    wire_master_pkg::slot_kind_t kind_reg;
    logic [`SLOT_CNT_W-1:0] cnt_reg;
    logic [`SLOT_CNT_W-1:0] low_len;
    logic [`SLOT_CNT_W-1:0] sample_at;
    logic [`SLOT_CNT_W-1:0] end_at;
    logic sync1_reg;
    logic sync2_reg;
    logic rx_reg;
    logic done_reg;

    // ======================================================================
    // Two-stage synchroniser on the line input
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= dq_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Slot shape per kind
    always_comb begin
        unique case (kind_reg)
            wire_master_pkg::SLOT_RESET: begin
                low_len = RST_LOW;
                sample_at = RST_SAMPLE;
                end_at = RST_END;
            end
            wire_master_pkg::SLOT_WRITE0: begin
                low_len = SLOT_END;
                sample_at = SLOT_END;
                end_at = SLOT_END;
            end
            wire_master_pkg::SLOT_WRITE1: begin
                low_len = W1_LOW;
                sample_at = SLOT_END;
                end_at = SLOT_END;
            end
            wire_master_pkg::SLOT_READ: begin
                low_len = RD_LOW;
                sample_at = RD_SAMPLE;
                end_at = SLOT_END;
            end
        endcase
    end

    // ======================================================================
    // Slot sequence: low phase, released phase, recovery
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= wire_master_pkg::EN_IDLE;
            kind_reg <= wire_master_pkg::SLOT_RESET;
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            unique case (state_reg)
                wire_master_pkg::EN_IDLE: begin
                    if (s.start) begin
                        state_reg <= wire_master_pkg::EN_ACTIVE;
                        kind_reg <= s.kind;
                        cnt_reg <= '0;
                    end
                end
                wire_master_pkg::EN_ACTIVE: begin
                    if (cnt_reg == end_at - 1'b1) begin
                        state_reg <= wire_master_pkg::EN_RECOVER;
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                wire_master_pkg::EN_RECOVER: begin
                    if (cnt_reg == REC_END - 1'b1) begin
                        state_reg <= wire_master_pkg::EN_IDLE;
                        done_reg <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: state_reg <= wire_master_pkg::EN_IDLE;
            endcase
        end
    end

    // Sample point; presence shows as a low line, read data as its level
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_reg <= 1'b0;
        end else if (state_reg == wire_master_pkg::EN_ACTIVE && cnt_reg == sample_at) begin
            rx_reg <= sync2_reg;
        end
    end

    // Only ever pulls low; release leaves the line to the pullup
    assign dq_oe = (state_reg == wire_master_pkg::EN_ACTIVE) && (cnt_reg < low_len);
    assign s.done = done_reg;
    assign s.rx_bit = rx_reg;

endmodule

// file: src/wire_master.sv
// Bus master for a single-wire open-drain sensor bus.
// Takes reset, byte, bit and pullup operations from user logic, runs them
// as timed slots on the line, checks a running CRC over read bytes and
// drives a separate strong pullup after conversion and copy commands when parasite_mode is set.
// Assumes an external pullup resistor on the line and, for parasite
// power, an external transistor switched by strong_pullup_en.
//
// Overview of operation
// - Every transaction opens with reset and presence
// - Master holds line low 480 us minimum
// - One bit crosses the bus per slot
// - Write slots 60 us, 1 us recovery between
// - Every write slot starts by pulling low
// - Write one releases line within 15 us
// - Write zero holds line low whole slot
// - Read slots follow read-memory and supply queries
// - Read slots may poll conversion and reload status
// - Read slots 60 us, 1 us recovery between
// - Read slot starts with at least 1 us low
// - Master releases and samples within 15 us
// - Short initiation, sample late in window
// - Select-by-ID then 64-bit identifier precede command
// - Strong pullup through conversion on parasite power
// - CRC over eight bytes checked against ninth
// - Master originates all slots except presence
// - Bytes travel least significant bit first
`include "wire_master_consts.svh"

module wire_master #(
    parameter int RESET_LOW = `RESET_LOW_CYC,
    parameter int RESET_RX = `RESET_RX_CYC,
    parameter int PRES_SAMPLE = `PRESENCE_SAMPLE_CYC,
    parameter int SLOT_LEN = `SLOT_CYC,
    parameter int CONV_PULLUP = `CONVERSION_DURATION_CYC,
    parameter int COPY_PULLUP = `COPY_PULLUP_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Operation request
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire wire_master_pkg::op_t cmd_op,
    input wire logic [7:0] cmd_data,
    // Power mode of the attached devices
    input wire logic parasite_mode,
    // Operation answer
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_presence,
    output logic crc_ok,
    // Line
    input wire logic dq_in,
    output logic dq_out,
    output logic dq_oe,
    output logic strong_pullup_en
);

    // ======================================================================
    // Declarations
    slot_if slot ();

    // Sequencer state
    wire_master_pkg::seq_state_t state_reg;
    wire_master_pkg::op_t op_reg;
    logic [7:0] shift_reg;
    logic [7:0] sent_reg;
    logic [2:0] bit_cnt_reg;
    logic start_reg;
    wire_master_pkg::slot_kind_t kind_reg;
    logic [`PULLUP_CNT_W-1:0] pullup_cnt_reg;

    // Check and answer
    logic [7:0] crc_reg;
    logic [7:0] crc_next;
    logic crc_fb;
    logic rsp_valid_reg;
    logic [7:0] rsp_data_reg;
    logic presence_reg;

    // Decode helpers
    logic byte_op;
    logic read_op;
    logic last_bit;
    logic [7:0] rx_shifted;
    logic [7:0] tx_shifted;
    logic is_conv;
    logic is_copy;

    // Hold lengths in cycles
    localparam logic [`PULLUP_CNT_W-1:0] CONV_LEN = `PULLUP_CNT_W'(CONV_PULLUP);
    localparam logic [`PULLUP_CNT_W-1:0] COPY_LEN = `PULLUP_CNT_W'(COPY_PULLUP);

    // ======================================================================
    // Slot timing engine
    // Engine owns the pin enable
    slot_engine #(
        .RESET_LOW(RESET_LOW),
        .RESET_RX(RESET_RX),
        .PRES_SAMPLE(PRES_SAMPLE),
        .SLOT_LEN(SLOT_LEN)
    ) u_engine (
        .ref_clk(ref_clk),
        .rst(rst),
        .s(slot.eng),
        .dq_in(dq_in),
        .dq_oe(dq_oe)
    );

    assign slot.start = start_reg;
    assign slot.kind = kind_reg;

    // ======================================================================
    // Operation decode
    assign byte_op = (op_reg == wire_master_pkg::OP_WRITE_BYTE)
        || (op_reg == wire_master_pkg::OP_READ_BYTE);
    assign read_op = (op_reg == wire_master_pkg::OP_READ_BYTE)
        || (op_reg == wire_master_pkg::OP_READ_BIT);

    // Byte ops end after bit 7
    assign last_bit = !byte_op || (bit_cnt_reg == 3'h7);

    // Received bits enter at the top so bit 0 ends up first-received
    assign rx_shifted = {slot.rx_bit, shift_reg[7:1]};
    assign tx_shifted = {1'b0, shift_reg[7:1]};

    // Whole byte; the shift register has moved on
    assign is_conv = (op_reg == wire_master_pkg::OP_WRITE_BYTE)
        && (sent_reg == `CMD_START_CONVERSION);
    assign is_copy = (op_reg == wire_master_pkg::OP_WRITE_BYTE)
        && (sent_reg == `CMD_COPY_WORKING);

    // Slot kind for the bit now at the bottom of the shift register
    function automatic wire_master_pkg::slot_kind_t kind_for(
        input wire_master_pkg::op_t op,
        input logic bit_val
    );
        if (op == wire_master_pkg::OP_RESET) begin
            kind_for = wire_master_pkg::SLOT_RESET;
        end else if (op == wire_master_pkg::OP_READ_BYTE
                || op == wire_master_pkg::OP_READ_BIT) begin
            kind_for = wire_master_pkg::SLOT_READ;
        end else if (bit_val) begin
            kind_for = wire_master_pkg::SLOT_WRITE1;
        end else begin
            kind_for = wire_master_pkg::SLOT_WRITE0;
        end
    endfunction

    // Request accepted only while nothing is on the line
    assign cmd_ready = (state_reg == wire_master_pkg::ST_IDLE);

    // ======================================================================
    // Sequencer: one slot per bit, bytes bit 0 first
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= wire_master_pkg::ST_IDLE;
            op_reg <= wire_master_pkg::OP_RESET;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
            start_reg <= 1'b0;
            kind_reg <= wire_master_pkg::SLOT_RESET;
            pullup_cnt_reg <= '0;
        end else begin
            // Start is a single-cycle pulse
            start_reg <= 1'b0;
            unique case (state_reg)
                wire_master_pkg::ST_IDLE: begin
                    if (cmd_valid) begin
                        op_reg <= cmd_op;
                        shift_reg <= cmd_data;
                        bit_cnt_reg <= 3'h0;
                        if (cmd_op == wire_master_pkg::OP_PULLUP) begin
                            // Manual hold, e.g. copy done by hand
                            state_reg <= wire_master_pkg::ST_PULLUP;
                            pullup_cnt_reg <= COPY_LEN;
                        end else begin
                            state_reg <= wire_master_pkg::ST_SLOT;
                            start_reg <= 1'b1;
                            kind_reg <= kind_for(cmd_op, cmd_data[0]);
                        end
                    end
                end

                wire_master_pkg::ST_SLOT: begin
                    if (slot.done) begin
                        if (last_bit) begin
                            state_reg <= wire_master_pkg::ST_IDLE;
                        end else begin
                            // Next slot only after the engine's recovery
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            start_reg <= 1'b1;
                            kind_reg <= kind_for(op_reg, tx_shifted[0]);
                        end
                        shift_reg <= read_op ? rx_shifted : tx_shifted;
                    end
                end

                wire_master_pkg::ST_PULLUP: begin
                    // Counts down to one
                    if (pullup_cnt_reg <= `PULLUP_CNT_W'(1)) begin
                        state_reg <= wire_master_pkg::ST_IDLE;
                    end
                    pullup_cnt_reg <= pullup_cnt_reg - 1'b1;
                end

                default: state_reg <= wire_master_pkg::ST_IDLE;
            endcase

            // Byte just sent was a conversion or copy command
            if (state_reg == wire_master_pkg::ST_SLOT && slot.done && last_bit
                    && parasite_mode && (is_conv || is_copy)) begin
                state_reg <= wire_master_pkg::ST_PULLUP;
                pullup_cnt_reg <= is_conv ? CONV_LEN : COPY_LEN;
            end
        end
    end

    // ======================================================================
    // Answer: one pulse per finished operation
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= 8'h00;
            presence_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= 1'b0;
            if (state_reg == wire_master_pkg::ST_SLOT && slot.done && last_bit) begin
                rsp_valid_reg <= (op_reg != wire_master_pkg::OP_WRITE_BYTE)
                    || !parasite_mode
                    || (sent_reg != `CMD_START_CONVERSION
                        && sent_reg != `CMD_COPY_WORKING);
                if (op_reg == wire_master_pkg::OP_RESET) begin
                    // Low at the sample point means a device answered
                    presence_reg <= !slot.rx_bit;
                    rsp_data_reg <= 8'h00;
                end else if (op_reg == wire_master_pkg::OP_READ_BYTE) begin
                    rsp_data_reg <= rx_shifted;
                end else if (op_reg == wire_master_pkg::OP_READ_BIT) begin
                    // Single bit, e.g. supply query or status poll
                    rsp_data_reg <= {7'h00, slot.rx_bit};
                end else begin
                    rsp_data_reg <= sent_reg;
                end
            end else if (state_reg == wire_master_pkg::ST_PULLUP
                    && pullup_cnt_reg <= `PULLUP_CNT_W'(1)) begin
                // Pullup-holding commands answer once the hold ends
                rsp_valid_reg <= 1'b1;
            end
        end
    end

    // Written byte remembered for the auto-pullup check
    // Trade-off: the answer to a conversion or copy command on parasite
    // power waits for the whole hold, so no other activity can slip in.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sent_reg <= 8'h00;
        end else if (state_reg == wire_master_pkg::ST_IDLE && cmd_valid) begin
            sent_reg <= cmd_data;
        end
    end

    // ======================================================================
    // Running CRC over every bit of each read byte (not single read bits), cleared by reset slots
    // Reflected form, LSB first like the data
    assign crc_fb = crc_reg[0] ^ slot.rx_bit;
    assign crc_next = {1'b0, crc_reg[7:1]} ^ (crc_fb ? `CRC_POLY_REFLECTED : 8'h00);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            crc_reg <= `CRC_INIT;
        end else if (state_reg == wire_master_pkg::ST_IDLE && cmd_valid
                && cmd_op == wire_master_pkg::OP_RESET) begin
            crc_reg <= `CRC_INIT;
        end else if (state_reg == wire_master_pkg::ST_SLOT && slot.done
                && op_reg == wire_master_pkg::OP_READ_BYTE) begin
            crc_reg <= crc_next;
        end
    end

    // ======================================================================
    // Outputs
    // Zero over all nine bytes means the check byte matched the eight
    assign crc_ok = (crc_reg == 8'h00);

    // Answer straight from its registers
    assign rsp_valid = rsp_valid_reg;
    assign rsp_data = rsp_data_reg;
    assign rsp_presence = presence_reg;

    // Pin value when enabled is always low; high comes from the pullup
    assign dq_out = 1'b0;
    assign strong_pullup_en = (state_reg == wire_master_pkg::ST_PULLUP);

endmodule

// file: verification/wire_master_sva.sv
// Port checker for the bus master: pulse widths, recovery, handshake, pullup.
// Assumes binding to wire_master with the same shortened timing parameters.
module wire_master_sva #(
    parameter int RESET_LOW = 3000, parameter int SLOT_LEN = 2700,
    parameter int CONV_PULLUP = 50, parameter int COPY_PULLUP = 60
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Request and line
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire wire_master_pkg::op_t cmd_op,
    input wire logic dq_oe,
    input wire logic strong_pullup_en
);
    // ====
    // Run lengths; the released run starts large so the first slot passes
    int on_n, off_n, pu_n;
    wire_master_pkg::op_t op_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            on_n <= 0;
            off_n <= 99999;
            pu_n <= 0;
            op_reg <= wire_master_pkg::OP_RESET;
        end else begin
            on_n <= dq_oe ? on_n + 1 : 0;
            off_n <= dq_oe ? 0 : off_n + 1;
            pu_n <= strong_pullup_en ? pu_n + 1 : 0;
            if (cmd_valid && cmd_ready) op_reg <= cmd_op;
        end
    end
    // ====
    // Properties
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence line_end;
        $fell(dq_oe);
    endsequence
    a_reset_width: assert property (line_end ##0 op_reg == wire_master_pkg::OP_RESET
        |-> on_n == RESET_LOW) else $error("reset low time wrong");
    a_write_width: assert property (line_end ##0 (op_reg == wire_master_pkg::OP_WRITE_BYTE
        || op_reg == wire_master_pkg::OP_WRITE_BIT) |-> on_n inside {1200, SLOT_LEN})
        else $error("write low time wrong");
    a_read_width: assert property (line_end ##0 (op_reg == wire_master_pkg::OP_READ_BYTE
        || op_reg == wire_master_pkg::OP_READ_BIT) |-> on_n == 200) else $error("read low wrong");
    a_slot_recovery: assert property ($rose(dq_oe) |-> off_n >= 200)
        else $error("recovery too short");
    a_reset_opens: assert property (cmd_valid && cmd_ready
        && cmd_op == wire_master_pkg::OP_RESET |-> ##[1:4] $rose(dq_oe)) else $error("no reset");
    a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
        else $error("ready after take");
    a_pullup_quiet: assert property (strong_pullup_en |-> !dq_oe && !cmd_ready)
        else $error("activity during pullup");
    a_pullup_len: assert property ($fell(strong_pullup_en)
        |-> pu_n inside {CONV_PULLUP, COPY_PULLUP}) else $error("pullup length wrong");
endmodule

// file: verification/sensor_model.sv
// Behavioural sensor on the line: presence, write sampling, read answers.
// Assumes ref_clk as its timebase and a pulled-up line formed by the bench.
module sensor_model #(
    parameter int RST_MIN = 2800, parameter int PRES_WAIT = 20, parameter int PRES_LEN = 100,
    parameter int WR_SAMPLE = 2000, parameter int RD_HOLD = 2650
) (
    // Line
    input wire logic ref_clk,
    input wire logic dq,
    output logic pull_low,
    // Bench control
    input wire logic [7:0] tx_byte,
    input wire logic answer_en,
    input wire logic pres_en,
    output logic [7:0] rx_byte
);
    logic dq_d = 1'b1;
    logic send0 = 1'b0;
    logic [2:0] bitn = 3'h0;
    int low_n = 0, t = 9999, pres_t = 0;
    // ====
    // Times scaled down with the master's shortened slots
    always @(posedge ref_clk) begin
        dq_d <= dq;
        low_n <= dq ? 0 : low_n + 1;
        t <= t + 1;
        pres_t <= (pres_t == 0 || pres_t > PRES_WAIT + PRES_LEN) ? 0 : pres_t + 1;
        if (dq_d && !dq && pres_t == 0) begin
            t <= 1;
            send0 <= !tx_byte[bitn];
        end
        if (!dq_d && dq && low_n >= RST_MIN) begin
            pres_t <= int'(pres_en);
            bitn <= 3'h0;
            t <= 9999;
        end
        if (t == WR_SAMPLE) begin
            rx_byte <= {dq, rx_byte[7:1]};
            bitn <= bitn + 3'h1;
        end
    end
    // Only ever pulls low; a zero is let go before the slot ends
    assign pull_low = (pres_t > PRES_WAIT && pres_t <= PRES_WAIT + PRES_LEN) ||
        (answer_en && send0 && t < RD_HOLD);
endmodule

// file: verification/tb.sv
// Bench for the bus master with a behavioural sensor on the line.
// Assumes the design sources, the sensor model and the port checker.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Signals; the line idles high through the pullup
    logic ref_clk = 0, rst = 1, cmd_valid = 0, parasite_mode = 0, answer_en = 0, pres_en = 1;
    logic cmd_ready, rsp_valid, rsp_presence, crc_ok, dq_out, dq_oe, strong_pullup_en, dev_low;
    wire_master_pkg::op_t cmd_op = wire_master_pkg::OP_RESET;
    logic [7:0] cmd_data = 8'h00, tx_byte = 8'h00, rsp_data, rx_byte, got;
    logic [31:0] seed = 32'hAEFB;
    int failures = 0, n_compared = 0, cycles = 0, pu_cycles = 0;
    wire logic dq_in = !(dq_oe || dev_low);
    wire_master #(.RESET_LOW(3000), .RESET_RX(400), .PRES_SAMPLE(60), .SLOT_LEN(2700),
        .CONV_PULLUP(50), .COPY_PULLUP(60)) wire_master_i (.ref_clk, .rst, .cmd_valid,
        .cmd_ready, .cmd_op, .cmd_data, .parasite_mode, .rsp_valid, .rsp_data, .rsp_presence,
        .crc_ok, .dq_in, .dq_out, .dq_oe, .strong_pullup_en);
    sensor_model sensor_model_i (.ref_clk, .dq(dq_in), .pull_low(dev_low), .tx_byte,
        .answer_en, .pres_en, .rx_byte);
    always #2.5 ref_clk = ~ref_clk;
    // Hang guard: about 86k cycles of traffic are expected
    always @(posedge ref_clk) begin
        cycles++;
        if (strong_pullup_en) pu_cycles++;
        if (cycles == 95000) begin
            check(8'h00, 8'h01, "timeout");
            results();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s: %h vs %h", $time, what, seen, exp);
        end
    endtask
    task automatic results();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One request held until taken, then a bounded wait for the answer
    task automatic op(input wire_master_pkg::op_t o, input logic [7:0] d);
        int n;
        n = 0;
        cmd_op = o;
        cmd_data = d;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) @(posedge ref_clk) #1;
        @(posedge ref_clk) #1;
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n++ < 40000) @(posedge ref_clk) #1;
        got = rsp_data;
        check(8'(rsp_valid), 8'h01, "answer");
        $display("op %0d done at %0t", o, $time);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 rst = 1'b0;
        op(wire_master_pkg::OP_RESET, 8'h00);
        check(8'(rsp_presence), 8'h01, "presence");
        seed = lfsr(seed);
        op(wire_master_pkg::OP_WRITE_BYTE, seed[7:0]);
        check(rx_byte, seed[7:0], "byte at sensor");
        check(got, seed[7:0], "byte echo");
        seed = lfsr(seed);
        tx_byte = seed[7:0];
        parasite_mode = seed[8];
        answer_en = 1'b1;
        op(wire_master_pkg::OP_READ_BYTE, 8'h00);
        check(got, tx_byte, "read byte");
        tx_byte = 8'h00;
        op(wire_master_pkg::OP_READ_BIT, 8'h00);
        check(got & 8'h01, 8'h00, "read zero bit");
        answer_en = 1'b0;
        for (int b = 0; b < 2; b++) begin
            op(wire_master_pkg::OP_WRITE_BIT, 8'(b));
            check(8'(rx_byte[7]), 8'(b), "bit at sensor");
        end
        op(wire_master_pkg::OP_PULLUP, 8'h00);
        parasite_mode = 1'b1;
        op(wire_master_pkg::OP_WRITE_BYTE, 8'h44);
        check(rx_byte, 8'h44, "convert command");
        check(8'(pu_cycles), 8'(60 + 50), "pullup cycles");
        parasite_mode = 1'b0;
        pres_en = 1'b0;
        op(wire_master_pkg::OP_RESET, 8'h00);
        check(8'(rsp_presence), 8'h00, "no presence");
        check(8'(crc_ok), 8'h01, "check cleared");
        results();
    end
endmodule
bind wire_master wire_master_sva #(.RESET_LOW(RESET_LOW), .SLOT_LEN(SLOT_LEN),
    .CONV_PULLUP(CONV_PULLUP), .COPY_PULLUP(COPY_PULLUP)) chk_i (.ref_clk, .rst,
    .cmd_valid, .cmd_ready, .cmd_op, .dq_oe, .strong_pullup_en);
